// >>> logic/syncc_consts.vh
// Purpose: Constants of the synchrocheck stage and switching block
// Assumes: 250 MHz pclk, APB word registers
// Notes: Field macros are bit ranges for part-selects
//
// Overview of operation
// - Sample blocking input once at the start of every program cycle.
// - Assert match_confirmed when synchronized and sampled blocking inactive.
// - Blocking present when match would assert gives blocked instead.
// - Match already asserted drops once blocking appears.
// - Settings writable only when third or fourth channel is in sync mode.
// - Node mode On/Blocked/Test/TestBlocked/Off, default On, gated by permission.
// - Forcing selector Normal or force blocked/match per stage, gated by permission.
// - Selector picks whether system voltage is bus side or line side.
// - Three stage enables, default off; disabled stage gives neither output unless forced.
// - Start policy Always, or check only while stage start input active.
// - Stage one reference: unused, three line, three phase (phase needs earth).
// - Stage two needs both channels in sync mode; line references only.
// - Stage three active only with channel three versus four selected.
// - Synchronized switching on stage one issues its own close command.
// - Close is advanced by breaker time, 0.005 s steps, default 0.05 s.
// - Close goes to one of five objects, default the first.
// - Report estimated time to synchronism in 0.005 s steps.
// - Report time of one full relative rotation in 0.005 s steps.
// - Report signed angle difference, +/-360 deg, 0.001 deg steps.
// - Synchronized only when magnitude, frequency, angle and live/dead all fit, or when bypass is set.
// - Each side live above live threshold, dead below dead threshold.
`ifndef SYNCC_CONSTS_VH
`define SYNCC_CONSTS_VH

// Timing
`define SYNCC_CYCLE_NS 5000000
`define SYNCC_CLK_NS 4
`define SYNCC_STEP_MS 5
`define SYNCC_MS_PER_S 1000
`define SYNCC_TURN_DEG 360
`define SYNCC_FULL_TURN 20'h57e40
`define SYNCC_EST_MAX 32'h00011940

// Register offsets
`define SYNCC_A_CTRL 8'h00
`define SYNCC_A_REF 8'h04
`define SYNCC_A_VTHR 8'h08
`define SYNCC_A_UDIFF 8'h0c
`define SYNCC_A_ADIFF 8'h10
`define SYNCC_A_FDIFF 8'h14
`define SYNCC_A_COND 8'h18
`define SYNCC_A_BKT 8'h1c
`define SYNCC_A_STAT 8'h20
`define SYNCC_A_ESTC 8'h24
`define SYNCC_A_ROT 8'h28
`define SYNCC_A_ANG 8'h2c

// Control fields
`define SYNCC_F_EN 2:0
`define SYNCC_F_STPOL 5:3
`define SYNCC_F_SIDE 6
`define SYNCC_F_MODE 9:7
`define SYNCC_F_FORCE 12:10
`define SYNCC_F_SWEN 13
`define SYNCC_F_OBJ 16:14
`define SYNCC_F_REF1 2:0
`define SYNCC_F_REF2 4:3
`define SYNCC_F_REF3 5
`define SYNCC_F_LO 15:0
`define SYNCC_F_HI 31:16
`define SYNCC_F_MASK 3:0
`define SYNCC_F_BYP 4
`define SYNCC_F_BKT 18:0

// Reset values
`define SYNCC_RST_CTRL 17'h00000
`define SYNCC_RST_REF 6'h00
`define SYNCC_RST_LIVE 16'h07d0
`define SYNCC_RST_DEAD 16'h07d0
`define SYNCC_RST_UDIFF 16'h00c8
`define SYNCC_RST_ADIFF 16'h012c
`define SYNCC_RST_FDIFF 16'h000a
`define SYNCC_RST_COND 5'h01
`define SYNCC_RST_BKT 19'h0000a

// Node modes
`define SYNCC_MODE_ON 3'h0
`define SYNCC_MODE_BLK 3'h1
`define SYNCC_MODE_TEST 3'h2
`define SYNCC_MODE_TBLK 3'h3
`define SYNCC_MODE_OFF 3'h4

// Reference, object and forcing selections
`define SYNCC_REF_NONE 3'h0
`define SYNCC_REF_LL_LAST 3'h3
`define SYNCC_REF_PH_LAST 3'h6
`define SYNCC_OBJ_LAST 3'h4
`define SYNCC_FORCE_NORMAL 3'h0

`endif

// >>> logic/syncc_stage.v
// Purpose: One synchrocheck stage: judgement, blocking and forcing
// Assumes: eval pulses once per program cycle after blocking sample
// Notes: Outputs are flip-flops updated on eval
`timescale 1ns/1ps
`default_nettype none
module syncc_stage #(
  parameter VW = 16,
  parameter AW = 20,
  parameter FW = 18
) (
  input wire pclk,
  input wire presetn,
  input wire eval,
  input wire active,
  input wire start_ok,
  input wire block_smp,
  input wire swap,
  input wire [VW-1:0] sys_v,
  input wire [VW-1:0] meas_v,
  input wire signed [AW-1:0] ang,
  input wire signed [FW-1:0] frq,
  input wire [15:0] live_thr,
  input wire [15:0] dead_thr,
  input wire [15:0] udiff,
  input wire [15:0] alim,
  input wire [15:0] flim,
  input wire [3:0] cond_mask,
  input wire bypass,
  input wire force_ok,
  input wire force_blk,
  output reg match_o,
  output reg blocked_o,
  output reg pre_ok_o
);
  reg [VW-1:0] bus_v;
  reg [VW-1:0] line_v;
  reg [VW-1:0] vd;
  reg [AW-1:0] aa;
  reg [FW-1:0] fa;
  reg bl, bd, ll, ld, cond_hit, sync_ok, pre_ok;

  always @* begin
    bus_v = swap ? meas_v : sys_v;
    line_v = swap ? sys_v : meas_v;
    bl = bus_v > live_thr;
    ll = line_v > live_thr;
    bd = bus_v < dead_thr;
    ld = line_v < dead_thr;
    cond_hit = (cond_mask[0] & bl & ll) | (cond_mask[1] & bl & ld) |
      (cond_mask[2] & bd & ll) | (cond_mask[3] & bd & ld);
    vd = (bus_v > line_v) ? bus_v - line_v : line_v - bus_v;
    aa = ang[AW-1] ? -ang : ang;
    fa = frq[FW-1] ? -frq : frq;
    pre_ok = bypass | (cond_hit & (vd < udiff) & ({14'h0, fa} < {16'h0, flim} * 32'ha));
    sync_ok = pre_ok & (bypass | ({12'h0, aa} < {16'h0, alim} * 32'ha));
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      match_o <= 1'b0;
      blocked_o <= 1'b0;
      pre_ok_o <= 1'b0;
    end else if (eval) begin
      pre_ok_o <= active & start_ok & pre_ok;
      if (force_ok) begin
        match_o <= 1'b1;
        blocked_o <= 1'b0;
      end else if (force_blk) begin
        match_o <= 1'b0;
        blocked_o <= 1'b1;
      end else if (!active || !start_ok) begin
        match_o <= 1'b0;
        blocked_o <= 1'b0;
      end else if (block_smp) begin
        match_o <= 1'b0;
        if (sync_ok && !match_o) begin
          blocked_o <= 1'b1;
        end
      end else begin
        blocked_o <= 1'b0;
        match_o <= sync_ok;
      end
    end
  end
endmodule // syncc_stage
`default_nettype wire

// >>> logic/syncc_top.v
// Purpose: Synchrocheck stages, settings registers and synchronized close
// Assumes: APB slave, measured quantities synchronous to pclk
// Notes: One wait state on every APB access
//
// The implementer's own choices: the APB interface to the registers and the placing of the registers.
`include "syncc_consts.vh"
`timescale 1ns/1ps
`default_nettype none
module syncc_top #(
  parameter CYCLE_CLKS = `SYNCC_CYCLE_NS / `SYNCC_CLK_NS,
  parameter CNT_W = 21,
  parameter VW = 16,
  parameter AW = 20,
  parameter FW = 18
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire block_in,
  input wire [2:0] stage_start_input,
  input wire third_voltage_channel_sync,
  input wire fourth_voltage_channel_sync,
  input wire phase_earth_avail,
  input wire node_mode_allowed,
  input wire stage_forcing_allowed,
  input wire [3*VW-1:0] line_volts,
  input wire [3*VW-1:0] phase_volts,
  input wire [VW-1:0] third_voltage_channel,
  input wire [VW-1:0] fourth_voltage_channel,
  input wire [3*AW-1:0] ang_diff,
  input wire [3*FW-1:0] freq_diff,
  output wire [2:0] match_confirmed,
  output wire [2:0] blocked,
  output reg [4:0] close_cmd
);
  localparam integer CNT_LAST_I = CYCLE_CLKS - 1;
  localparam [CNT_W-1:0] CNT_LAST = CNT_LAST_I[CNT_W-1:0];

  reg [16:0] ctrl_reg;
  reg [5:0] ref_reg;
  reg [15:0] live_reg;
  reg [15:0] dead_reg;
  reg [15:0] udiff_reg;
  reg [15:0] adiff_reg;
  reg [15:0] fdiff_reg;
  reg [4:0] cond_reg;
  reg [18:0] bkt_reg;
  reg [CNT_W-1:0] cnt_reg;
  reg tick_reg;
  reg eval_reg;
  reg blk_smp_reg;
  reg close_done_reg;
  reg [16:0] estc_reg;
  reg [16:0] rot_reg;
  reg [AW-1:0] ang_reg;
  reg [31:0] rd_next;
  reg rd_err;
  reg [VW-1:0] sys1, sys2, meas1;
  reg [2:0] act;
  reg [2:0] force_eff;
  reg [2:0] mode_eff;
  reg blocking;
  reg [19:0] ang_n, rem;
  reg [FW-1:0] f_abs;
  reg [31:0] num_c, num_r, den, estc_next, rot_next;
  reg close_hit;
  wire [2:0] pre_ok;
  wire [VW*3-1:0] sys_bus;
  wire [VW*3-1:0] meas_bus;
  wire settings_open;
  wire wr_en;
  wire [AW-1:0] ang1;
  wire [FW-1:0] frq1;
  wire [2:0] stage_en;
  wire [2:0] start_pol;

  assign settings_open = third_voltage_channel_sync | fourth_voltage_channel_sync;
  assign wr_en = psel & penable & pwrite & pready & settings_open;
  assign ang1 = ang_diff[AW-1:0];
  assign frq1 = freq_diff[FW-1:0];
  assign stage_en = ctrl_reg[`SYNCC_F_EN];
  assign start_pol = ctrl_reg[`SYNCC_F_STPOL];

  // Program cycle timer
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= {CNT_W{1'b0}};
      tick_reg <= 1'b0;
      eval_reg <= 1'b0;
      blk_smp_reg <= 1'b0;
    end else begin
      tick_reg <= (cnt_reg == CNT_LAST);
      eval_reg <= tick_reg;
      cnt_reg <= (cnt_reg == CNT_LAST) ? {CNT_W{1'b0}} : cnt_reg + 1'b1;
      if (tick_reg) begin
        blk_smp_reg <= block_in;
      end
    end
  end

  // Settings registers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= `SYNCC_RST_CTRL;
      ref_reg <= `SYNCC_RST_REF;
      live_reg <= `SYNCC_RST_LIVE;
      dead_reg <= `SYNCC_RST_DEAD;
      udiff_reg <= `SYNCC_RST_UDIFF;
      adiff_reg <= `SYNCC_RST_ADIFF;
      fdiff_reg <= `SYNCC_RST_FDIFF;
      cond_reg <= `SYNCC_RST_COND;
      bkt_reg <= `SYNCC_RST_BKT;
    end else if (wr_en) begin
      case (paddr)
        `SYNCC_A_CTRL: begin
          ctrl_reg[`SYNCC_F_EN] <= pwdata[`SYNCC_F_EN];
          ctrl_reg[`SYNCC_F_STPOL] <= pwdata[`SYNCC_F_STPOL];
          ctrl_reg[`SYNCC_F_SIDE] <= pwdata[`SYNCC_F_SIDE];
          ctrl_reg[`SYNCC_F_SWEN] <= pwdata[`SYNCC_F_SWEN];
          if (node_mode_allowed && pwdata[`SYNCC_F_MODE] <= `SYNCC_MODE_OFF) begin
            ctrl_reg[`SYNCC_F_MODE] <= pwdata[`SYNCC_F_MODE];
          end
          if (stage_forcing_allowed) begin
            ctrl_reg[`SYNCC_F_FORCE] <= pwdata[`SYNCC_F_FORCE];
          end
          if (pwdata[`SYNCC_F_OBJ] <= `SYNCC_OBJ_LAST) begin
            ctrl_reg[`SYNCC_F_OBJ] <= pwdata[`SYNCC_F_OBJ];
          end
        end
        `SYNCC_A_REF: begin
          if (pwdata[`SYNCC_F_REF1] <= `SYNCC_REF_LL_LAST ||
              (phase_earth_avail && pwdata[`SYNCC_F_REF1] <= `SYNCC_REF_PH_LAST)) begin
            ref_reg[`SYNCC_F_REF1] <= pwdata[`SYNCC_F_REF1];
          end
          ref_reg[`SYNCC_F_REF2] <= pwdata[`SYNCC_F_REF2];
          ref_reg[`SYNCC_F_REF3] <= pwdata[`SYNCC_F_REF3];
        end
        `SYNCC_A_VTHR: begin
          live_reg <= pwdata[`SYNCC_F_LO];
          dead_reg <= pwdata[`SYNCC_F_HI];
        end
        `SYNCC_A_UDIFF: udiff_reg <= pwdata[`SYNCC_F_LO];
        `SYNCC_A_ADIFF: adiff_reg <= pwdata[`SYNCC_F_LO];
        `SYNCC_A_FDIFF: fdiff_reg <= pwdata[`SYNCC_F_LO];
        `SYNCC_A_COND: cond_reg <= pwdata[4:0];
        `SYNCC_A_BKT: bkt_reg <= pwdata[`SYNCC_F_BKT];
        default: begin
        end
      endcase
    end
  end

  // Stage availability, mode and references
  always @* begin
    mode_eff = node_mode_allowed ? ctrl_reg[`SYNCC_F_MODE] : `SYNCC_MODE_ON;
    force_eff = stage_forcing_allowed ? ctrl_reg[`SYNCC_F_FORCE] : `SYNCC_FORCE_NORMAL;
    blocking = blk_smp_reg | (mode_eff == `SYNCC_MODE_BLK) | (mode_eff == `SYNCC_MODE_TBLK);
    act[0] = stage_en[0] & settings_open & (ref_reg[`SYNCC_F_REF1] != `SYNCC_REF_NONE) &
      (phase_earth_avail | (ref_reg[`SYNCC_F_REF1] <= `SYNCC_REF_LL_LAST));
    act[1] = stage_en[1] & third_voltage_channel_sync & fourth_voltage_channel_sync &
      (ref_reg[`SYNCC_F_REF2] != 2'h0);
    act[2] = stage_en[2] & third_voltage_channel_sync & fourth_voltage_channel_sync &
      ref_reg[`SYNCC_F_REF3];
    if (mode_eff == `SYNCC_MODE_OFF) begin
      act = 3'h0;
    end
    case (ref_reg[`SYNCC_F_REF1])
      3'h1: sys1 = line_volts[VW-1:0];
      3'h2: sys1 = line_volts[2*VW-1:VW];
      3'h3: sys1 = line_volts[3*VW-1:2*VW];
      3'h4: sys1 = phase_volts[VW-1:0];
      3'h5: sys1 = phase_volts[2*VW-1:VW];
      3'h6: sys1 = phase_volts[3*VW-1:2*VW];
      default: sys1 = {VW{1'b0}};
    endcase
    case (ref_reg[`SYNCC_F_REF2])
      2'h1: sys2 = line_volts[VW-1:0];
      2'h2: sys2 = line_volts[2*VW-1:VW];
      2'h3: sys2 = line_volts[3*VW-1:2*VW];
      default: sys2 = {VW{1'b0}};
    endcase
    meas1 = third_voltage_channel_sync ? third_voltage_channel : fourth_voltage_channel;
  end

  assign sys_bus = {third_voltage_channel, sys2, sys1};
  assign meas_bus = {fourth_voltage_channel, fourth_voltage_channel, meas1};

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_stage
      localparam integer FBLK_I = 2 * gi + 1;
      localparam integer FOK_I = 2 * gi + 2;
      localparam [2:0] FBLK = FBLK_I[2:0];
      localparam [2:0] FOK = FOK_I[2:0];
      syncc_stage #(
        .VW(VW),
        .AW(AW),
        .FW(FW)
      ) u_stage (
        .pclk(pclk),
        .presetn(presetn),
        .eval(eval_reg),
        .active(act[gi]),
        .start_ok(~start_pol[gi] | stage_start_input[gi]),
        .block_smp(blocking),
        .swap(ctrl_reg[`SYNCC_F_SIDE]),
        .sys_v(sys_bus[gi*VW +: VW]),
        .meas_v(meas_bus[gi*VW +: VW]),
        .ang(ang_diff[gi*AW +: AW]),
        .frq(freq_diff[gi*FW +: FW]),
        .live_thr(live_reg),
        .dead_thr(dead_reg),
        .udiff(udiff_reg),
        .alim(adiff_reg),
        .flim(fdiff_reg),
        .cond_mask(cond_reg[`SYNCC_F_MASK]),
        .bypass(cond_reg[`SYNCC_F_BYP]),
        .force_ok(force_eff == FOK),
        .force_blk(force_eff == FBLK),
        .match_o(match_confirmed[gi]),
        .blocked_o(blocked[gi]),
        .pre_ok_o(pre_ok[gi])
      );
    end
  endgenerate

  // Estimates for stage one
  always @* begin
    f_abs = frq1[FW-1] ? -frq1 : frq1;
    ang_n = ang1[AW-1] ? ang1 + `SYNCC_FULL_TURN : ang1;
    if (ang_n >= `SYNCC_FULL_TURN) begin
      ang_n = 20'h0;
    end
    rem = frq1[FW-1] ? ang_n : ((ang_n == 20'h0) ? 20'h0 : `SYNCC_FULL_TURN - ang_n);
    num_c = {12'h0, rem} * `SYNCC_MS_PER_S;
    num_r = {12'h0, `SYNCC_FULL_TURN} * `SYNCC_MS_PER_S;
    den = {14'h0, f_abs} * (`SYNCC_TURN_DEG * `SYNCC_STEP_MS);
    if (f_abs == {FW{1'b0}}) begin
      estc_next = `SYNCC_EST_MAX;
      rot_next = `SYNCC_EST_MAX;
    end else begin
      estc_next = num_c / den;
      rot_next = num_r / den;
      if (estc_next > `SYNCC_EST_MAX) begin
        estc_next = `SYNCC_EST_MAX;
      end
      if (rot_next > `SYNCC_EST_MAX) begin
        rot_next = `SYNCC_EST_MAX;
      end
    end
    close_hit = ctrl_reg[`SYNCC_F_SWEN] & act[0] & pre_ok[0] & ~blocking &
      ({15'h0, estc_reg} <= {13'h0, bkt_reg});
  end

  // Estimates and synchronized close
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      estc_reg <= 17'h0;
      rot_reg <= 17'h0;
      ang_reg <= {AW{1'b0}};
      close_done_reg <= 1'b0;
      close_cmd <= 5'h00;
    end else begin
      close_cmd <= 5'h00;
      if (eval_reg) begin
        estc_reg <= estc_next[16:0];
        rot_reg <= rot_next[16:0];
        ang_reg <= ang1;
        close_done_reg <= close_hit;
        if (close_hit && !close_done_reg) begin
          close_cmd <= 5'h01 << ctrl_reg[`SYNCC_F_OBJ];
        end
      end
    end
  end

  // APB read mux
  always @* begin
    rd_err = 1'b0;
    case (paddr)
      `SYNCC_A_CTRL: rd_next = {15'h0, ctrl_reg};
      `SYNCC_A_REF: rd_next = {26'h0, ref_reg};
      `SYNCC_A_VTHR: rd_next = {dead_reg, live_reg};
      `SYNCC_A_UDIFF: rd_next = {16'h0, udiff_reg};
      `SYNCC_A_ADIFF: rd_next = {16'h0, adiff_reg};
      `SYNCC_A_FDIFF: rd_next = {16'h0, fdiff_reg};
      `SYNCC_A_COND: rd_next = {27'h0, cond_reg};
      `SYNCC_A_BKT: rd_next = {13'h0, bkt_reg};
      `SYNCC_A_STAT: rd_next = {24'h0, close_done_reg, blk_smp_reg, blocked, match_confirmed};
      `SYNCC_A_ESTC: rd_next = {15'h0, estc_reg};
      `SYNCC_A_ROT: rd_next = {15'h0, rot_reg};
      `SYNCC_A_ANG: rd_next = {{(32-AW){ang_reg[AW-1]}}, ang_reg};
      default: begin
        rd_next = 32'h0;
        rd_err = 1'b1;
      end
    endcase
  end

  // APB handshake, one wait state
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else begin
      pready <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & rd_err;
      if (psel && penable && !pready && !pwrite) begin
        prdata <= rd_next;
      end
    end
  end
endmodule // syncc_top
`default_nettype wire

// >>> tb/syncc_assertions.sv
// Purpose: Port-level checks of syncc_top
// Assumes: CYCLE_CLKS of at least 9
// Notes: Attached by bind below
`timescale 1ns/1ps
`default_nettype none
module syncc_assertions #(
  parameter CYCLE_CLKS = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic block_in,
  input wire logic node_mode_allowed,
  input wire logic stage_forcing_allowed,
  input wire logic [2:0] match_confirmed,
  input wire logic [2:0] blocked,
  input wire logic [4:0] close_cmd
);
  int blk_cnt;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Length of the present blocking level
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      blk_cnt <= 0;
    else if (!block_in)
      blk_cnt <= 0;
    else if (blk_cnt < 255)
      blk_cnt <= blk_cnt + 1;
  end
  sequence s_wait;
    psel && penable && !pready;
  endsequence
  sequence s_done;
    psel && penable && pready;
  endsequence
  chk_apb_wait:
    assert property (s_wait |=> pready) else $error("ready late");
  chk_ready_pulse:
    assert property (pready |=> !pready) else $error("ready too long");
  chk_err_map:
    assert property ((s_done and (paddr[1:0] == 2'h0)) |-> pslverr == (paddr > 8'h2c))
    else $error("slave error wrong");
  chk_rd_unmapped:
    assert property ((s_done and (!pwrite && paddr > 8'h2c)) |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  chk_match_excl:
    assert property ((match_confirmed & blocked) == 3'h0) else $error("match with blocked");
  chk_block_drop:
    assert property (blk_cnt > CYCLE_CLKS + 4 && !stage_forcing_allowed
      |-> match_confirmed == 3'h0) else $error("match kept under blocking");
  chk_blk_cause:
    assert property ($rose(blocked[0]) && !stage_forcing_allowed && !node_mode_allowed
      |-> $past(block_in, 2)) else $error("blocked without blocking");
  chk_out_steady:
    assert property ($changed({match_confirmed, blocked})
      |=> $stable({match_confirmed, blocked})[*8]) else $error("outputs change twice");
  chk_close_onehot:
    assert property ($onehot0(close_cmd)) else $error("close to several objects");
  chk_close_pulse:
    assert property (|close_cmd |=> close_cmd == 5'h00) else $error("close too long");
  cover_close: cover property (|close_cmd);
endmodule // syncc_assertions
bind syncc_top syncc_assertions #(.CYCLE_CLKS(CYCLE_CLKS)) u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .block_in(block_in),
  .node_mode_allowed(node_mode_allowed), .stage_forcing_allowed(stage_forcing_allowed),
  .match_confirmed(match_confirmed), .blocked(blocked), .close_cmd(close_cmd));
`default_nettype wire

// >>> tb/syncc_partner.sv
// Purpose: Blocking matrix and breaker objects
// Assumes: Blocking request level from the bench
// Notes: A breaker latches closed on its close pulse
`timescale 1ns/1ps
`default_nettype none
module syncc_partner (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic blk_req,
  input wire logic [4:0] close_cmd,
  output logic block_in,
  output logic [4:0] closed
);
  // Level changes just after the edge
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      block_in <= 1'b0;
      closed <= 5'h00;
    end else begin
      block_in <= blk_req;
      closed <= closed | close_cmd;
    end
  end
endmodule // syncc_partner
`default_nettype wire

// >>> tb/tb_top.sv
// Purpose: Self-checking bench of syncc_top
// Assumes: Program cycle cut to 16 clocks
// Notes: Settings reached over APB
`timescale 1ns/1ps
`default_nettype none
`include "syncc_consts.vh"
`define CHK(g, e) begin \
  cmp_count++; \
  if ((g) !== (e)) begin \
    n_mismatch++; \
    $display("wrong value at %0t: got %h want %h", $time, g, e); \
  end \
end
module tb_top;
  localparam int CYC = 16;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic blk_req = 1'b0;
  logic [2:0] start = 3'h0;
  logic ch3 = 1'b0;
  logic ch4 = 1'b0;
  logic pe = 1'b0;
  logic mode_ok = 1'b0;
  logic force_ok = 1'b0;
  logic [47:0] lv = 48'h0;
  logic [47:0] pv = 48'h0;
  logic [15:0] v3 = 16'h0;
  logic [15:0] v4 = 16'h0;
  logic [59:0] ang = 60'h0;
  logic [53:0] frq = 54'h0;
  logic [31:0] rdat;
  logic rerr;
  wire [31:0] prdata;
  wire pready;
  wire pslverr;
  wire block_in;
  wire [2:0] mc;
  wire [2:0] bk;
  wire [4:0] cc;
  wire [4:0] closed;
  int n_mismatch = 0;
  int cmp_count = 0;
  logic [31:0] rst_tab [8] = '{32'h0, 32'h0, 32'h07d007d0, 32'hc8, 32'h12c, 32'ha, 32'h1, 32'ha};
  always #2 pclk = ~pclk;
  syncc_top #(.CYCLE_CLKS(CYC)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .block_in(block_in), .stage_start_input(start), .third_voltage_channel_sync(ch3),
    .fourth_voltage_channel_sync(ch4), .phase_earth_avail(pe), .node_mode_allowed(mode_ok),
    .stage_forcing_allowed(force_ok), .line_volts(lv), .phase_volts(pv),
    .third_voltage_channel(v3), .fourth_voltage_channel(v4), .ang_diff(ang),
    .freq_diff(frq), .match_confirmed(mc), .blocked(bk), .close_cmd(cc));
  syncc_partner part (
    .pclk(pclk), .presetn(presetn), .blk_req(blk_req), .close_cmd(cc),
    .block_in(block_in), .closed(closed));
  task automatic end_sim;
    if (n_mismatch == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      n_mismatch++;
      end_sim();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(rdat, e)
  endtask
  task automatic cyc(input int k);
    repeat (k * CYC) @(posedge pclk);
  endtask
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 8; i++) rd(8'(i * 4), rst_tab[i]);
    apb(1'b0, 8'h30, 32'h0);
    `CHK({rerr, rdat}, 33'h100000000)
    wr(`SYNCC_A_CTRL, 32'h1);
    rd(`SYNCC_A_CTRL, 32'h0);
    ch3 <= 1'b1;
    wr(`SYNCC_A_CTRL, 32'h80);
    rd(`SYNCC_A_CTRL, 32'h0);
    mode_ok <= 1'b1;
    for (int m = 0; m < 6; m++) begin
      wr(`SYNCC_A_CTRL, 32'(m) << 7);
      rd(`SYNCC_A_CTRL, 32'(m > 4 ? 4 : m) << 7);
    end
    mode_ok <= 1'b0;
    wr(`SYNCC_A_CTRL, 32'h440);
    rd(`SYNCC_A_CTRL, 32'h240);
    force_ok <= 1'b1;
    for (int f = 1; f < 7; f++) begin
      wr(`SYNCC_A_CTRL, 32'(f) << 10);
      cyc(2);
      `CHK({bk, mc}, 6'h1 << ((f - 1) / 2 + (f % 2) * 3))
    end
    force_ok <= 1'b0;
    lv <= 48'd10000;
    v3 <= 16'd10000;
    wr(`SYNCC_A_REF, 32'h1);
    wr(`SYNCC_A_CTRL, 32'h0);
    cyc(3);
    `CHK(mc, 3'h0)
    wr(`SYNCC_A_CTRL, 32'h9);
    cyc(3);
    `CHK(mc, 3'h0)
    start <= 3'h7;
    cyc(3);
    `CHK(mc, 3'h1)
    blk_req <= 1'b1;
    cyc(3);
    `CHK(mc, 3'h0)
    wr(`SYNCC_A_CTRL, 32'h0);
    cyc(3);
    wr(`SYNCC_A_CTRL, 32'h1);
    cyc(3);
    `CHK({bk, mc}, 6'h08)
    blk_req <= 1'b0;
    cyc(3);
    `CHK({bk, mc}, 6'h01)
    v3 <= 16'd10300;
    cyc(3);
    `CHK(mc, 3'h0)
    v3 <= 16'd1000;
    lv <= 48'd1000;
    cyc(3);
    `CHK(mc, 3'h0)
    wr(`SYNCC_A_COND, 32'h8);
    cyc(3);
    `CHK(mc, 3'h1)
    wr(`SYNCC_A_COND, 32'h1);
    v3 <= 16'd10000;
    lv <= 48'd10000;
    wr(`SYNCC_A_REF, 32'h4);
    rd(`SYNCC_A_REF, 32'h1);
    pe <= 1'b1;
    wr(`SYNCC_A_REF, 32'h4);
    wr(`SYNCC_A_REF, 32'h7);
    rd(`SYNCC_A_REF, 32'h4);
    cyc(3);
    `CHK(mc, 3'h0)
    pv <= 48'd10000;
    cyc(3);
    `CHK(mc, 3'h1)
    v4 <= 16'd10000;
    wr(`SYNCC_A_REF, 32'h9);
    wr(`SYNCC_A_CTRL, 32'h7);
    cyc(3);
    `CHK(mc, 3'h1)
    ch4 <= 1'b1;
    cyc(3);
    `CHK(mc, 3'h3)
    wr(`SYNCC_A_REF, 32'h29);
    cyc(3);
    `CHK(mc, 3'h7)
    `CHK(closed, 5'h00)
    ang <= {40'h0, 20'hff8f8};
    frq <= {36'h0, 18'd5};
    wr(`SYNCC_A_BKT, 32'd20);
    wr(`SYNCC_A_CTRL, 32'ha001);
    cyc(4);
    `CHK(closed, 5'h00)
    rd(`SYNCC_A_ESTC, 32'd200);
    rd(`SYNCC_A_ROT, 32'd40000);
    apb(1'b0, `SYNCC_A_ANG, 32'h0);
    `CHK(rdat[19:0], 20'hff8f8)
    wr(`SYNCC_A_BKT, 32'd200);
    for (int k = 0; k < 640 && closed === 5'h00; k++) @(posedge pclk);
    `CHK(closed, 5'h04)
    end_sim();
  end
endmodule // tb_top
`default_nettype wire
